// ---- hw/jpe_pkg.sv ----
// shared types and constants for the joystick parameter editor
package jpe_pkg;
	localparam int VAL_W = 16;
	localparam int IDX_W = 5;
	localparam int SCHED_W = 7;
	localparam int DEPTH_W = 3;
	localparam int CNT_W = 32;
	localparam int JOY_W = 7;
	localparam int NUM_SCHED = 100;
	localparam int NUM_PARAMS = 16;
	localparam int CLK_FREQ_HZ = 10000000;
	localparam int HELP_TIME_MS = 3000;
	localparam int FLASH_TIME_MS = 500;
	localparam int HELP_CYCLES = HELP_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int FLASH_CYCLES = FLASH_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int PCT_DIV = 100;
	localparam int GAIN_LO_PCT = 1;
	localparam int GAIN_HI_PCT = 5;
	localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
	localparam logic [IDX_W-1:0] SEL_RST = 5'h00;
	localparam logic [DEPTH_W-1:0] DEPTH_RST = 3'h0;
	localparam logic WELD_EN_RST = 1'b1;

	// joystick contacts, one bit per action
	typedef struct packed {
		logic prev_select_action;
		logic return_menu_action;
		logic next_select_action;
		logic down;
		logic increase_step;
		logic decrease_step;
		logic accept;
	} jpe_joy_s;

	typedef enum logic [2:0] {
		GAIN_UNIT = 3'h1,
		GAIN_ONE_PCT = 3'h2,
		GAIN_FIVE_PCT = 3'h4
	} jpe_gain_e;

	typedef enum logic [1:0] {
		HELP_NONE = 2'h0,
		HELP_FIRST_ITEM = 2'h1,
		HELP_LAST_ITEM = 2'h2
	} jpe_help_e;

	typedef enum logic [1:0] {
		MODE_BROWSE = 2'h1,
		MODE_EDIT = 2'h2
	} jpe_mode_e;

	// what the pendant display shows
	typedef struct packed {
		logic [IDX_W-1:0] inverted_line;
		logic [DEPTH_W-1:0] menu_depth;
		logic [VAL_W-1:0] value;
		jpe_help_e help_msg;
		logic weld_enabled;
		logic weld_lamp;
		logic gain_one_percent_tag;
		logic gain_five_percent_tag;
		logic edit_lock_tag;
		logic edit_pending;
	} jpe_disp_s;

	typedef struct packed {
		jpe_mode_e mode;
		logic [IDX_W-1:0] sel;
		logic [DEPTH_W-1:0] depth;
		logic [VAL_W-1:0] val;
		jpe_gain_e gain;
		logic weld_en;
		jpe_help_e help;
		logic [CNT_W-1:0] help_cnt;
		logic [CNT_W-1:0] flash_cnt;
		logic flash;
		jpe_disp_s disp;
	} jpe_state_s;

	typedef struct packed {
		jpe_joy_s s1;
		jpe_joy_s s2;
		jpe_joy_s s3;
		jpe_joy_s pulse;
	} jpe_sync_s;
endpackage

// ---- hw/jpe_joy_sync.sv ----
// joystick contact synchroniser and closing-edge detector
`timescale 1ns/1ps
module jpe_joy_sync (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire jpe_pkg::jpe_joy_s raw,
	output jpe_pkg::jpe_joy_s pulse
);
	import jpe_pkg::*;

	jpe_sync_s st_reg;
	jpe_sync_s st_next;

	// s1 is read only by s2; the edge looks at s2 and s3
	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.pulse = st_reg.s2 & ~st_reg.s3; // R21
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pulse = st_reg.pulse;
endmodule

// ---- hw/jpe_editor.sv ----
// joystick driven parameter editor with per-schedule parameter storage
`timescale 1ns/1ps
// Behaviour
// [R1] joystick gives left, up, right, down toggles, rotation steps and push
// [R2] previous-select moves selection to the preceding parameter
// [R3] previous-select on the first parameter shows first-item help for three seconds
// [R4] next-select moves selection to the following parameter
// [R5] next-select on the last parameter shows last-item help for three seconds
// [R6] return goes to main menu, or up one level inside a sub-menu
// [R7] down toggles weld enable where assigned; disabled shows flashing lamp
// [R8] down cycles gain among unit, one percent and five percent where assigned
// [R9] gain tag blank at unit gain, flashing one or five percent tag otherwise
// [R10] clockwise step at unit gain adds one to displayed value
// [R11] clockwise step adds one or five percent of maximum when gain applies
// [R12] increase at maximum wraps to minimum
// [R13] counter-clockwise step at unit gain subtracts one
// [R14] counter-clockwise step subtracts one or five percent of maximum when gain applies
// [R15] decrease at minimum wraps to maximum
// [R16] accept stores displayed value and advances to next parameter
// [R17] moving selection before accept discards the edit
// [R18] edit lock enabled shows flashing lock tag on title line
// [R19] selected line shown inverted
// [R20] storage holds up to one hundred schedules
// [R21] each contact closing acts exactly once; a closing seen in the same cycle as a higher-priority one does not act
module jpe_editor #(
	parameter int NUM_PARAMS = jpe_pkg::NUM_PARAMS,
	parameter int NUM_SCHED = jpe_pkg::NUM_SCHED,
	parameter int HELP_CYCLES = jpe_pkg::HELP_CYCLES,
	parameter int FLASH_CYCLES = jpe_pkg::FLASH_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire jpe_pkg::jpe_joy_s joy_raw,
	input wire logic [jpe_pkg::SCHED_W-1:0] schedule_sel,
	input wire logic [jpe_pkg::IDX_W-1:0] menu_len,
	input wire logic [jpe_pkg::VAL_W-1:0] param_min,
	input wire logic [jpe_pkg::VAL_W-1:0] param_max,
	input wire logic param_gain_ctrl,
	input wire logic down_is_weld_toggle,
	input wire logic down_is_gain_toggle,
	input wire logic edit_lock_en,
	output jpe_pkg::jpe_disp_s disp
);
	import jpe_pkg::*;

	localparam int MEM_DEPTH = NUM_SCHED * NUM_PARAMS;
	localparam int ADDR_W = $clog2(MEM_DEPTH);

	jpe_state_s st_reg;
	jpe_state_s st_next;
	jpe_joy_s act;
	logic [VAL_W-1:0] mem [MEM_DEPTH];
	logic [ADDR_W-1:0] mem_addr;
	logic [VAL_W-1:0] mem_rd;
	logic mem_we;
	logic sched_ok;
	logic is_first;
	logic is_last;
	// one written flag per word; a word never stored reads as the reset value
	logic [MEM_DEPTH-1:0] mem_vld;

	// each contact yields a single pulse per closing
	jpe_joy_sync u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.raw(joy_raw),
		.pulse(act)
	);

	// step size from gain; percent steps only for gain-controlled parameters
	function automatic logic [VAL_W-1:0] step_of(input jpe_gain_e g, input logic ctrl,
		input logic [VAL_W-1:0] pmax);
		logic [VAL_W+3:0] wide;
		wide = '0;
		if (!ctrl || g == GAIN_UNIT) begin
			wide = {{(VAL_W+3){1'b0}}, 1'b1}; // R10 R13
		end else if (g == GAIN_ONE_PCT) begin
			wide = ({4'h0, pmax} * (VAL_W+4)'(GAIN_LO_PCT)) / (VAL_W+4)'(PCT_DIV); // R11 R14
		end else begin
			wide = ({4'h0, pmax} * (VAL_W+4)'(GAIN_HI_PCT)) / (VAL_W+4)'(PCT_DIV); // R11 R14
		end
		// a floor of one keeps narrow ranges editable at percent gain
		if (wide == '0) begin
			wide = {{(VAL_W+3){1'b0}}, 1'b1};
		end
		step_of = wide[VAL_W-1:0];
	endfunction

	// raise with wrap at maximum; a step overshooting maximum stops at maximum
	function automatic logic [VAL_W-1:0] raise(input logic [VAL_W-1:0] v,
		input logic [VAL_W-1:0] s, input logic [VAL_W-1:0] lo, input logic [VAL_W-1:0] hi);
		logic [VAL_W:0] sum;
		sum = {1'b0, v} + {1'b0, s};
		if (v >= hi) begin
			raise = lo; // R12
		end else if (sum > {1'b0, hi}) begin
			raise = hi;
		end else begin
			raise = sum[VAL_W-1:0];
		end
	endfunction

	// lower with wrap at minimum; a step undershooting minimum stops at minimum
	function automatic logic [VAL_W-1:0] lower(input logic [VAL_W-1:0] v,
		input logic [VAL_W-1:0] s, input logic [VAL_W-1:0] lo, input logic [VAL_W-1:0] hi);
		if (v <= lo) begin
			lower = hi; // R15
		end else if (v - lo < s) begin
			lower = lo;
		end else begin
			lower = v - s;
		end
	endfunction

	// address of the selected parameter inside the chosen schedule
	assign sched_ok = ({1'b0, schedule_sel} < (SCHED_W+1)'(NUM_SCHED)); // R20
	assign mem_addr = ADDR_W'(schedule_sel * NUM_PARAMS + st_reg.sel);
	// the flag keeps unknown contents of unwritten storage off the display
	assign mem_rd = (sched_ok && mem_vld[mem_addr]) ? mem[mem_addr] : VAL_RST; // R20
	assign is_first = (st_reg.sel == SEL_RST);
	assign is_last = ({1'b0, st_reg.sel} + 1'b1 >= {1'b0, menu_len});

	// one action per cycle; accept first, then navigation, then down, then rotation
	always_comb begin
		st_next = st_reg;
		mem_we = 1'b0;
		// flash base shared by every blinking tag
		if (st_reg.flash_cnt + 1'b1 >= CNT_W'(FLASH_CYCLES)) begin
			st_next.flash_cnt = '0;
			st_next.flash = ~st_reg.flash;
		end else begin
			st_next.flash_cnt = st_reg.flash_cnt + 1'b1;
		end

		// help message times out on its own
		if (st_reg.help != HELP_NONE) begin
			if (st_reg.help_cnt + 1'b1 >= CNT_W'(HELP_CYCLES)) begin
				st_next.help = HELP_NONE; // R3 R5
				st_next.help_cnt = '0;
			end else begin
				st_next.help_cnt = st_reg.help_cnt + 1'b1;
			end
		end

		// while not editing the displayed value follows storage
		if (st_reg.mode == MODE_BROWSE) begin
			st_next.val = mem_rd;
		end

		// store and step on; at the last line the selection stays put
		if (act.accept) begin
			mem_we = sched_ok; // R16
			st_next.mode = MODE_BROWSE;
			if (!is_last) begin
				st_next.sel = st_reg.sel + 1'b1; // R16
			end
		end else if (act.prev_select_action) begin
			// at the top only the warning changes, a pending edit survives
			if (is_first) begin
				st_next.help = HELP_FIRST_ITEM; // R3
				st_next.help_cnt = '0;
			end else begin
				st_next.sel = st_reg.sel - 1'b1; // R2
				st_next.mode = MODE_BROWSE; // R17
			end
		end else if (act.next_select_action) begin
			// at the bottom only the warning changes, a pending edit survives
			if (is_last) begin
				st_next.help = HELP_LAST_ITEM; // R5
				st_next.help_cnt = '0;
			end else begin
				st_next.sel = st_reg.sel + 1'b1; // R4
				st_next.mode = MODE_BROWSE; // R17
			end
		end else if (act.return_menu_action) begin
			// leaving a menu also drops any unsaved edit
			if (st_reg.depth != DEPTH_RST) begin
				st_next.depth = st_reg.depth - 1'b1; // R6
			end
			st_next.sel = SEL_RST;
			st_next.mode = MODE_BROWSE;
		end else if (act.down) begin
			// gain wins when a screen assigns both uses to down
			if (down_is_gain_toggle) begin
				case (st_reg.gain) // R8
					GAIN_UNIT: begin
						st_next.gain = GAIN_ONE_PCT;
					end
					GAIN_ONE_PCT: begin
						st_next.gain = GAIN_FIVE_PCT;
					end
					default: begin
						st_next.gain = GAIN_UNIT;
					end
				endcase
			end else if (down_is_weld_toggle) begin
				st_next.weld_en = ~st_reg.weld_en; // R7
			end
		end else if (act.increase_step) begin
			// rotation edits only the displayed copy until accept
			st_next.val = raise(st_reg.val, step_of(st_reg.gain, param_gain_ctrl, param_max),
				param_min, param_max);
			st_next.mode = MODE_EDIT;
		end else if (act.decrease_step) begin
			st_next.val = lower(st_reg.val, step_of(st_reg.gain, param_gain_ctrl, param_max),
				param_min, param_max);
			st_next.mode = MODE_EDIT;
		end

		// display image taken from the next state so outputs are registered
		st_next.disp.inverted_line = st_next.sel; // R19
		st_next.disp.menu_depth = st_next.depth;
		st_next.disp.value = st_next.val;
		st_next.disp.help_msg = st_next.help;
		// down-arrow area: steady when enabled, blinking while firing is blocked
		st_next.disp.weld_enabled = st_next.weld_en;
		st_next.disp.weld_lamp = st_next.weld_en | st_next.flash; // R7
		// title line tags all blink off the one flash base
		st_next.disp.gain_one_percent_tag = (st_next.gain == GAIN_ONE_PCT) & st_next.flash; // R9
		st_next.disp.gain_five_percent_tag = (st_next.gain == GAIN_FIVE_PCT) & st_next.flash; // R9
		st_next.disp.edit_lock_tag = edit_lock_en & st_next.flash; // R18
		st_next.disp.edit_pending = (st_next.mode == MODE_EDIT);
	end

	// state register; weld defaults to enabled, lamp steady
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.mode <= MODE_BROWSE;
			st_reg.gain <= GAIN_UNIT;
			st_reg.weld_en <= WELD_EN_RST;
			st_reg.help <= HELP_NONE;
			st_reg.disp.weld_enabled <= WELD_EN_RST;
			st_reg.disp.weld_lamp <= WELD_EN_RST;
			st_reg.disp.help_msg <= HELP_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	// schedule storage; no reset so it can map to block memory
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[mem_addr] <= st_reg.val; // R16
		end
	end

	// written flags; cleared by reset so a fresh schedule reads as the reset value
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mem_vld <= '0;
		end else if (mem_we) begin
			mem_vld[mem_addr] <= 1'b1; // R16
		end
	end

	assign disp = st_reg.disp;
endmodule

// ---- verif/jpe_editor_chk.sv ----
// concurrent checks on the editor display outputs
`timescale 1ns/1ps
module jpe_editor_chk #(
	parameter int HELP_CYCLES = 20,
	parameter int FLASH_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic edit_lock_en,
	input wire jpe_pkg::jpe_disp_s disp
);
	import jpe_pkg::*;
	localparam int HELP_LIM = HELP_CYCLES + 4;
	localparam int FLASH_LIM = 2 * FLASH_CYCLES + 2;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// help text raised and still standing
	sequence s_help_on;
		disp.help_msg != HELP_NONE;
	endsequence
	property p_help_hold;
		$rose(disp.help_msg != HELP_NONE) |-> s_help_on [*8];
	endproperty
	a_help_hold: assert property (p_help_hold) else $error("help text dropped early");
	property p_help_end;
		disp.help_msg != HELP_NONE |-> ##[1:HELP_LIM] disp.help_msg == HELP_NONE;
	endproperty
	a_help_end: assert property (p_help_end) else $error("help text never cleared");
	property p_gain_excl;
		!(disp.gain_one_percent_tag && disp.gain_five_percent_tag);
	endproperty
	a_gain_excl: assert property (p_gain_excl) else $error("both gain tags lit");
	property p_lock_off;
		!edit_lock_en && !$past(edit_lock_en) |-> !disp.edit_lock_tag;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("lock tag without lock");
	// enabled weld is shown steadily, disabled must blink
	property p_lamp;
		disp.weld_enabled && $past(disp.weld_enabled) |-> disp.weld_lamp;
	endproperty
	a_lamp: assert property (p_lamp) else $error("weld lamp not steady");
	property p_flash;
		$fell(disp.weld_enabled) |-> ##[1:FLASH_LIM] $changed(disp.weld_lamp);
	endproperty
	a_flash: assert property (p_flash) else $error("weld lamp not blinking");
	// selection only moves by one or back to the top
	property p_sel_step;
		$changed(disp.inverted_line) |-> disp.inverted_line == $past(disp.inverted_line) + 5'h01
			|| disp.inverted_line == $past(disp.inverted_line) - 5'h01
			|| disp.inverted_line == 5'h00;
	endproperty
	a_sel_step: assert property (p_sel_step) else $error("selection jumped");
	property p_depth;
		$changed(disp.menu_depth) |-> disp.menu_depth == $past(disp.menu_depth) - 3'h1;
	endproperty
	a_depth: assert property (p_depth) else $error("menu depth went deeper");
	property p_discard;
		$changed(disp.inverted_line) |-> !disp.edit_pending;
	endproperty
	a_discard: assert property (p_discard) else $error("edit kept after move");
endmodule
bind jpe_editor jpe_editor_chk #(.HELP_CYCLES(HELP_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .edit_lock_en(edit_lock_en), .disp(disp));

// ---- verif/jpe_op_model.sv ----
// operator joystick: closes one contact, holds it, then opens it
`timescale 1ns/1ps
module jpe_op_model (
	input wire logic clk_sys,
	output jpe_pkg::jpe_joy_s joy
);
	import jpe_pkg::*;
	initial joy = '0;
	// open gap of five cycles so the next closing is seen as new
	task automatic press(input int a, input int hold);
		@(posedge clk_sys);
		#5 joy[a] = 1'b1;
		repeat (hold) @(posedge clk_sys);
		#5 joy = '0;
		repeat (5) @(posedge clk_sys);
		#5;
	endtask
endmodule

// ---- verif/jpe_editor_test.sv ----
// self-checking bench for the joystick parameter editor
`timescale 1ns/1ps
module jpe_editor_test;
	import jpe_pkg::*;
	logic clk_sys = 0;
	logic sys_rst = 1;
	jpe_joy_s joy;
	jpe_disp_s disp;
	logic [15:0] pmax = 16'h0064;
	logic [15:0] pmin = 16'h0000;
	logic [6:0] sched = 7'h05;
	logic [4:0] mlen = 5'h04;
	logic gctl = 0, wtog = 0, gtog = 0, lock = 0;
	logic [3:0] hi_seen = 4'h0, lo_seen = 4'h0;
	logic [3:0] blink;
	int failures = 0, n_checks = 0, pct = 0;
	logic [15:0] cur = 16'h0000;
	logic [15:0] st0 = 16'h0000;
	always #50 clk_sys = ~clk_sys;
	// short help and flash counts keep the run brief
	jpe_editor #(.HELP_CYCLES(20), .FLASH_CYCLES(4)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .joy_raw(joy), .schedule_sel(sched), .menu_len(mlen),
		.param_min(pmin), .param_max(pmax), .param_gain_ctrl(gctl),
		.down_is_weld_toggle(wtog), .down_is_gain_toggle(gtog), .edit_lock_en(lock),
		.disp(disp));
	jpe_op_model u_op (.clk_sys(clk_sys), .joy(joy));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	// next displayed value; overshoot clamps, a step from the limit wraps
	function automatic logic [15:0] nxt(input logic [15:0] v, input bit up);
		int s;
		s = (pct == 0 || !gctl) ? 1 : pmax * pct / 100;
		if (s < 1) s = 1;
		if (up) return (v >= pmax) ? pmin : ((v + s > pmax) ? pmax : 16'(v + s));
		return (v <= pmin) ? pmax : ((v - pmin < s) ? pmin : 16'(v - s));
	endfunction
	task automatic step(input bit up);
		u_op.press(up ? 2 : 1, 2 + $urandom % 20);
		cur = nxt(cur, up);
		chk(disp.value, cur);
	endtask
	// blinking outputs: one and five percent tags, weld lamp, lock tag
	assign blink = {disp.gain_one_percent_tag, disp.gain_five_percent_tag, disp.weld_lamp,
		disp.edit_lock_tag};
	// note which levels each blinking output shows over one and a half flash periods
	task automatic watch;
		hi_seen = 4'h0;
		lo_seen = 4'h0;
		repeat (12) begin
			@(posedge clk_sys);
			#5;
			hi_seen = hi_seen | blink;
			lo_seen = lo_seen | ~blink;
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog at 20000 cycles, well beyond the expected several hundred cycles
	initial begin
		#(100 * 20000);
		failures++;
		final_report();
	end
	initial begin
		void'($urandom(88));
		pmax = 16'h0064 + 16'($urandom % 200);
		pmin = 16'($urandom % 20);
		mlen = 5'h04 + 5'($urandom % 4);
		repeat (20) @(posedge clk_sys);
		#5 sys_rst = 0;
		repeat (3) @(posedge clk_sys);
		#5;
		chk(disp.weld_enabled, 1);
		chk(disp.inverted_line, 0);
		step(0);
		step(1);
		repeat (6) step($urandom % 2);
		gctl = 1;
		gtog = 1;
		for (int g = 0; g < 3; g++) begin
			u_op.press(3, 3);
			watch();
			chk({hi_seen[3:2], lo_seen[3:2]}, (g == 0) ? 4'hB : (g == 1) ? 4'h7 : 4'h3);
			pct = (g == 0) ? 1 : (g == 1) ? 5 : 0;
			step(1);
			step(1);
			step(0);
		end
		chk({disp.gain_one_percent_tag, disp.gain_five_percent_tag}, 0);
		st0 = cur;
		u_op.press(0, 2);
		chk(disp.inverted_line, 1);
		cur = 16'h0000;
		chk(disp.value, cur);
		step(1);
		chk(disp.edit_pending, 1);
		u_op.press(6, 2);
		chk(disp.inverted_line, 0);
		chk(disp.edit_pending, 0);
		chk(disp.value, st0);
		u_op.press(4, 2);
		chk(disp.value, 0);
		u_op.press(6, 2);
		u_op.press(6, 4);
		chk(disp.help_msg, HELP_FIRST_ITEM);
		chk(disp.inverted_line, 0);
		repeat (25) @(posedge clk_sys);
		#5;
		chk(disp.help_msg, HELP_NONE);
		for (int i = 1; i < mlen; i++) begin
			u_op.press(4, 2);
			chk(disp.inverted_line, i);
		end
		u_op.press(4, 2);
		chk(disp.help_msg, HELP_LAST_ITEM);
		u_op.press(5, 3);
		chk(disp.inverted_line, 0);
		chk(disp.menu_depth, 0);
		gtog = 0;
		wtog = 1;
		u_op.press(3, 2);
		chk(disp.weld_enabled, 0);
		watch();
		chk({hi_seen[1], lo_seen[1]}, 2'b11);
		u_op.press(3, 2);
		chk(disp.weld_enabled, 1);
		watch();
		chk(lo_seen[1], 0);
		lock = 1;
		watch();
		chk({hi_seen[0], lo_seen[0]}, 2'b11);
		// another schedule keeps its own words; beyond the last nothing is stored
		sched = 7'(NUM_SCHED - 1);
		repeat (2) @(posedge clk_sys);
		#5;
		chk(disp.value, 0);
		cur = 16'h0000;
		step(1);
		u_op.press(0, 2);
		u_op.press(6, 2);
		chk(disp.value, cur);
		sched = 7'h05;
		repeat (2) @(posedge clk_sys);
		#5;
		chk(disp.value, st0);
		sched = 7'(NUM_SCHED);
		repeat (2) @(posedge clk_sys);
		#5;
		chk(disp.value, 0);
		final_report();
	end
endmodule
